// [hdl/twep_port.sv]
// two-wire serial eeprom target: bus engine, write buffer, array
//
// Behaviour
// (RQ1) data and command bits are taken at the clock line's rising edge
// (RQ2) returned data changes only after a falling clock edge
// (RQ3) respond only when the address matches the strap inputs, else stay passive
// (RQ4) three straps give eight distinct addresses on one shared bus
// (RQ5) write-protect high suppresses every array write; low lets writes proceed
// (RQ6) undriven strap and protect inputs count as low; the code has no pull-downs, only the synchroniser reset loads them low
// (RQ7) data line only pulled low or released, never driven high
// (RQ8) the master keeps the clock high while the bus is idle
// (RQ9) page writes of up to eight bytes; partial pages write only those bytes
// (RQ10) accepted writes program on internal timing within five milliseconds
// (RQ11) random, current-address and sequential reads are supported
// (RQ12) array is 128 or 256 bytes with matching address width
// (RQ13) works at clock rates up to one megahertz
// (RQ14) three address bits compared to the straps; acknowledge only on full match
`timescale 1ns/1ps
module twep_port
    import twep_pkg::*;
#(
    parameter int unsigned MEM_DEPTH = twep_pkg::MEM_DEPTH_DEF, // 128 or 256
    parameter int unsigned WR_WAIT   = twep_pkg::WR_CYCLES      // programming cycles
) (
    input  wire logic i_clk,                  // 200 MHz system clock
    input  wire logic i_reset_n,              // sync reset, active low
    input  wire logic i_scl,                  // serial clock pin
    input  wire logic i_sda,                  // serial data pin level
    output logic      o_sda,                  // data pin output, always low
    output logic      o_sda_oe_n,             // low pulls data line low
    input  wire logic i_chip_select_strap_bit0, // address strap 0
    input  wire logic i_chip_select_strap_bit1, // address strap 1
    input  wire logic i_chip_select_strap_bit2, // address strap 2
    input  wire logic i_write_protect,        // high blocks array writes
    output logic      o_busy                  // internal write cycle running
);
    import twep_pkg::*;

    localparam int unsigned AW = $clog2(MEM_DEPTH);
    localparam int unsigned TW = $clog2(WR_WAIT + 1);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // only the two array densities are served
    if (MEM_DEPTH != 128 && MEM_DEPTH != 256) begin : g_bad_depth
        $error("array depth must be 128 or 256");                     // [RQ12]
    end

    if (WR_WAIT < 1) begin : g_bad_wait
        $error("programming wait must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [5:0]         sync1_q;
    logic [5:0]         sync2_q;
    logic               scl_prev_q;
    logic               sda_prev_q;
    logic               scl_s;
    logic               sda_s;
    logic [2:0]         strap;
    logic               wp;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_evt;
    logic               stop_evt;

    twep_state_t        state_q;
    logic [3:0]         bit_cnt_q;
    logic               ack_slot_q;
    logic [7:0]         rx_q;
    logic [7:0]         tx_q;
    logic [AW-1:0]      addr_q;
    logic [AW-1:0]      addr_inc;
    logic [AW-1:0]      addr_page_inc;
    logic               dev_hit;
    logic               byte_done;
    logic               sda_oe_n_q;
    logic               sda_out_q;

    logic               push_q;
    twep_wr_ent_t       push_ent_q;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    twep_wr_ent_t       fifo_out;
    logic               drain_q;
    logic               pop;
    logic [TW-1:0]      timer_q;
    logic               busy_q;

    logic [7:0]         mem_q [MEM_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // two flops on every pin; scl/sda reset to idle high, straps low
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync1_q <= SYNC_RST;                                       // [RQ6]
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= {i_write_protect, i_chip_select_strap_bit2,
                        i_chip_select_strap_bit1, i_chip_select_strap_bit0,
                        i_sda, i_scl};
            sync2_q <= sync1_q;
        end
    end

    // previous synchronised levels for edge detection
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= sync2_q[0];
            sda_prev_q <= sync2_q[1];
        end
    end

    // edges and bus conditions; 5 ns sampling far outruns a 1 MHz clock
    assign scl_s     = sync2_q[0];                                     // [RQ13]
    assign sda_s     = sync2_q[1];
    assign strap     = sync2_q[4:2];
    assign wp        = sync2_q[5];
    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    // data moving while clock stays high marks start or stop
    assign start_evt = scl_s & scl_prev_q & sda_prev_q & ~sda_s;       // [RQ8]
    assign stop_evt  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // address decode and address arithmetic

    // full match of code and all three strap bits, eight distinct slots
    assign dev_hit       = (rx_q[7:4] == CTRL_CODE) &&
                           (rx_q[3:1] == strap);                       // [RQ3] [RQ4] [RQ14]
    assign byte_done     = (bit_cnt_q == BITS_PER_BYTE);
    // sequential reads roll over the whole array
    assign addr_inc      = addr_q + AW'(1);                            // [RQ11]
    // page writes roll over within the 8-byte page
    assign addr_page_inc = {addr_q[AW-1:PAGE_W],
                            addr_q[PAGE_W-1:0] + PAGE_W'(1)};          // [RQ9]

    ////////////////////////////////////////////////////////////////////////////
    // bus engine

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q    <= ST_IDLE;
            bit_cnt_q  <= '0;
            ack_slot_q <= 1'b0;
            rx_q       <= '0;
            tx_q       <= '0;
            addr_q     <= '0;
            sda_oe_n_q <= 1'b1;
            push_q     <= 1'b0;
            push_ent_q <= '0;
        end else begin
            push_q <= 1'b0;
            if (start_evt) begin
                // start or repeated start: expect a target address
                state_q    <= ST_DEV;
                bit_cnt_q  <= '0;
                ack_slot_q <= 1'b0;
                sda_oe_n_q <= 1'b1;
            end else if (stop_evt) begin
                state_q    <= ST_IDLE;
                ack_slot_q <= 1'b0;
                sda_oe_n_q <= 1'b1;
            end else if (scl_rise) begin
                if (state_q == ST_RACK) begin
                    // master acknowledge low asks for the next byte
                    addr_q    <= addr_inc;                             // [RQ11]
                    tx_q      <= mem_q[addr_inc];
                    bit_cnt_q <= '0;
                    state_q   <= sda_s ? ST_IDLE : ST_RDATA;
                end else if (!ack_slot_q) begin
                    rx_q      <= {rx_q[6:0], sda_s};                   // [RQ1]
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end else if (scl_fall) begin
                if (ack_slot_q) begin
                    // end of our acknowledge: release or start read data
                    ack_slot_q <= 1'b0;
                    bit_cnt_q  <= '0;
                    if (state_q == ST_RDATA) begin
                        sda_oe_n_q <= tx_q[7];                         // [RQ2] [RQ7]
                        tx_q       <= {tx_q[6:0], 1'b0};
                    end else begin
                        sda_oe_n_q <= 1'b1;
                    end
                end else if (byte_done) begin
                    case (state_q)
                        ST_DEV: begin
                            // busy programming: no acknowledge, passive
                            if (dev_hit && !busy_q) begin              // [RQ3]
                                ack_slot_q <= 1'b1;
                                sda_oe_n_q <= 1'b0;                    // [RQ7]
                                if (rx_q[RW_BIT]) begin
                                    state_q <= ST_RDATA;
                                    tx_q    <= mem_q[addr_q];          // [RQ11]
                                end else begin
                                    state_q <= ST_WORD;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_WORD: begin
                            addr_q     <= rx_q[AW-1:0];                // [RQ12]
                            ack_slot_q <= 1'b1;
                            sda_oe_n_q <= 1'b0;
                            state_q    <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            // full buffer refuses the byte with no acknowledge
                            if (fifo_in_ready) begin
                                push_q          <= 1'b1;               // [RQ9]
                                push_ent_q.addr <= 8'(addr_q);
                                push_ent_q.data <= rx_q;
                                addr_q          <= addr_page_inc;
                                ack_slot_q      <= 1'b1;
                                sda_oe_n_q      <= 1'b0;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_RDATA: begin
                            // release for the master's acknowledge bit
                            sda_oe_n_q <= 1'b1;
                            state_q    <= ST_RACK;
                        end
                        default: begin
                            state_q <= state_q;
                        end
                    endcase
                end else if (state_q == ST_RDATA) begin
                    // next read bit only after the falling edge
                    sda_oe_n_q <= tx_q[7];                             // [RQ2]
                    tx_q       <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

    // data pin output level is fixed low; only the enable moves
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;                                         // [RQ7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write buffer

    // bytes wait here until stop starts the programming cycle
    twep_fifo #(
        .WIDTH ($bits(twep_wr_ent_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_valid   (push_q),
        .o_ready   (fifo_in_ready),
        .i_data    (push_ent_q),
        .o_valid   (fifo_out_valid),
        .i_ready   (drain_q),
        .o_data    (fifo_out)
    );

    assign pop = drain_q & fifo_out_valid;

    ////////////////////////////////////////////////////////////////////////////
    // self-timed programming cycle

    // stop after buffered bytes starts the cycle; protect skips the wait
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            drain_q <= 1'b0;
            timer_q <= '0;
            busy_q  <= 1'b0;
        end else begin
            if (stop_evt && fifo_out_valid && !busy_q) begin
                drain_q <= 1'b1;
                busy_q  <= 1'b1;
                timer_q <= wp ? '0 : TW'(WR_WAIT);                     // [RQ10] [RQ5]
            end else begin
                if (drain_q && !fifo_out_valid) begin
                    drain_q <= 1'b0;
                end
                if (timer_q != '0) begin
                    timer_q <= timer_q - TW'(1);                       // [RQ10]
                end
                if (!drain_q && timer_q == '0) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // array update; protect discards the buffered bytes
    always_ff @(posedge i_clk) begin
        if (pop && !wp) begin                                          // [RQ5]
            mem_q[fifo_out.addr[AW-1:0]] <= fifo_out.data;             // [RQ12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_sda      = sda_out_q;
    assign o_sda_oe_n = sda_oe_n_q;
    assign o_busy     = busy_q;

endmodule // twep_port

// [pkg/twep_pkg.sv]
// shared constants and types for the two-wire eeprom target port
package twep_pkg;

    // clock rate and self-timed programming time
    localparam int unsigned CLK_FREQ_MHZ  = 200;
    localparam int unsigned WR_TIME_US    = 5000;        // longest programming time
    localparam int unsigned WR_CYCLES     = WR_TIME_US * CLK_FREQ_MHZ; // exact product

    // memory organisation
    localparam int unsigned MEM_DEPTH_DEF = 256;         // 128 or 256 bytes
    localparam int unsigned PAGE_W        = 3;           // 8-byte page
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned FIFO_DEPTH    = 16;

    // target address byte layout: code[7:4], straps[3:1], read flag[0]
    localparam logic [3:0]  CTRL_CODE     = 4'hA;
    localparam int unsigned RW_BIT        = 0;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    // synchroniser reset: {wp, strap2, strap1, strap0, sda, scl}
    localparam logic [5:0]  SYNC_RST      = 6'h03;

    // bus-side state
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } twep_state_t;

    // one buffered write: target byte address and data
    typedef struct packed {
        logic [BYTE_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } twep_wr_ent_t;

endpackage

// [hdl/twep_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module twep_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             i_clk,     // system clock
    input  wire logic             i_reset_n, // sync reset, active low
    input  wire logic             i_valid,   // write request
    output logic                  o_ready,   // space available
    input  wire logic [WIDTH-1:0] i_data,    // write data
    output logic                  o_valid,   // data available
    input  wire logic             i_ready,   // reader takes data
    output logic      [WIDTH-1:0] o_data     // head of queue
);
    localparam int unsigned AW = $clog2(DEPTH);

    // elaboration check on depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count
    assign o_ready = (count_q != (AW+1)'(DEPTH));
    assign o_valid = (count_q != '0);
    assign o_data  = mem_q[rd_ptr_q];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    // storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_data;
        end
    end

    // pointers and count
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + AW'(push);
            rd_ptr_q <= rd_ptr_q + AW'(pop);
            count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // twep_fifo

// [tb/twep_props.sv]
// concurrent checks on the eeprom target port pins
`timescale 1ns/1ps
module twep_props #(
    parameter int unsigned WR_WAIT = 400
) (
    input wire logic i_clk,           // system clock
    input wire logic i_reset_n,       // sync reset, active low
    input wire logic i_scl,           // serial clock pin
    input wire logic o_sda,           // data pin value
    input wire logic o_sda_oe_n,      // data pin enable
    input wire logic i_write_protect, // blocks array writes
    input wire logic o_busy           // programming cycle
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic [31:0] busy_q;
    // length of the current busy stretch
    always_ff @(posedge i_clk) begin
        busy_q <= (o_busy && i_reset_n) ? busy_q + 32'h1 : 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence held_low;
        !o_sda_oe_n [*8];
    endsequence
    sequence quiet_rise;
        $stable(o_sda_oe_n) [*4];
    endsequence
    AST_OD_LOW: assert property (!o_sda_oe_n |-> o_sda == 1'b0)
        else $error("data pin driven high");
    AST_CHANGE_AFTER_FALL: assert property ($changed(o_sda_oe_n) |-> !i_scl && $past(i_scl, 6))
        else $error("data changed away from a clock fall");
    AST_HOLD_LOW: assert property ($fell(o_sda_oe_n) |-> held_low)
        else $error("driven bit too short");
    AST_RISE_QUIET: assert property ($rose(i_scl) |-> quiet_rise)
        else $error("data moved around a clock rise");
    AST_RESET_IDLE: assert property ($rose(i_reset_n) |-> o_sda_oe_n && !o_busy)
        else $error("bus not released after reset");
    AST_BUSY_DEAF: assert property (o_busy |-> o_sda_oe_n)
        else $error("answer while programming");
    AST_BUSY_MAX: assert property (busy_q <= WR_WAIT + 32'h20)
        else $error("programming too long");
    AST_BUSY_MIN: assert property ($fell(o_busy) |-> i_write_protect || busy_q + 8 >= WR_WAIT)
        else $error("programming too short");
    AST_WP_SHORT: assert property ($rose(o_busy) && i_write_protect |-> ##[1:40] !o_busy)
        else $error("protected write took a full cycle");
endmodule // twep_props
bind twep_port twep_props #(.WR_WAIT(WR_WAIT)) u_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .i_write_protect(i_write_protect), .o_busy(o_busy));

// [tb/twep_master.sv]
// two-wire bus master model: drives the clock, pulls data low
`timescale 1ns/1ps
module twep_master (
    input  wire logic i_clk,  // system clock
    input  wire logic i_sda,  // resolved data wire
    output logic      o_scl,  // serial clock
    output logic      o_pull  // high pulls data low
);
    // idle bus: clock high, data released to pull-up
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // one bit, 16 clocks: data set in low phase, sampled mid high phase
    task automatic bit_io(input logic v, output logic s);
        o_pull <= !v;
        tick(4);
        o_scl <= 1'b1;
        tick(4);
        @(negedge i_clk);
        s = i_sda;
        tick(4);
        o_scl <= 1'b0;
        tick(4);
    endtask
    // start or repeated start
    task automatic start();
        o_pull <= 1'b0;
        tick(4);
        o_scl <= 1'b1;
        tick(8);
        o_pull <= 1'b1;
        tick(8);
        o_scl <= 1'b0;
        tick(4);
    endtask
    // stop leaves the clock high
    task automatic stop();
        o_pull <= 1'b1;
        tick(4);
        o_scl <= 1'b1;
        tick(8);
        o_pull <= 1'b0;
        tick(8);
    endtask
    // byte out msb first, then the target's acknowledge
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // byte in, then our acknowledge when more is wanted
    task automatic recv(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, s);
    endtask
endmodule // twep_master

// [tb/test_twep_port.sv]
// self-checking bench for the two-wire eeprom target port
`timescale 1ns/1ps
module test_twep_port;
    import twep_pkg::*;
    localparam int unsigned WR_WAIT = 400;
    logic       i_clk;
    logic       i_reset_n;
    logic       i_write_protect;
    logic [2:0] strap;
    logic       o_sda;
    logic       o_sda_oe_n;
    logic       o_busy;
    logic       scl;
    logic       pull;
    logic       sda;
    logic       ack;
    logic [7:0] d;
    logic [7:0] exp_mem [256];
    int         fails;
    int         tests_run;
    // wired-and data line with pull-up
    assign sda = ((!o_sda_oe_n && !o_sda) || pull) ? 1'b0 : 1'b1;
    twep_port #(.MEM_DEPTH(256), .WR_WAIT(WR_WAIT)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n), .i_chip_select_strap_bit0(strap[0]),
        .i_chip_select_strap_bit1(strap[1]), .i_chip_select_strap_bit2(strap[2]),
        .i_write_protect(i_write_protect), .o_busy(o_busy));
    twep_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic dev(input logic rw);
        m.start();
        m.send({CTRL_CODE, strap, rw}, ack);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < WR_WAIT + 100) begin
            @(negedge i_clk);
            n++;
        end
        // back onto the rising edge so the next drive stays on it
        @(posedge i_clk);
        if (n >= WR_WAIT + 100) begin
            fails++;
            end_of_test();
        end
    endtask
    // page write; bytes past a full buffer are refused; busy target refuses its address
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] v);
        dev(1'b0);
        m.send(a, ack);
        for (int i = 0; i < n; i++) begin
            m.send(v + 8'(i), ack);
            chk({7'h0, ack}, {7'h0, i < int'(FIFO_DEPTH)});
            if (!i_write_protect && i < int'(FIFO_DEPTH))
                exp_mem[{a[7:3], 3'(a[2:0] + 3'(i))}] = v + 8'(i);
        end
        m.stop();
        if (!i_write_protect) begin
            chk({7'h0, o_busy}, 8'h01);
            dev(1'b0);
            chk({7'h0, ack}, 8'h00);
            m.stop();
        end
        wait_idle();
    endtask
    // random read followed by sequential bytes, last one refused
    task automatic rd(input logic [7:0] a, input int n);
        dev(1'b0);
        m.send(a, ack);
        dev(1'b1);
        for (int i = 0; i < n; i++) begin
            m.recv(i < n - 1, d);
            chk(d, exp_mem[a + 8'(i)]);
        end
        m.stop();
    endtask
    ////////////////////////////////////////////////////////////////////////
    // only the strapped address answers; low straps select code zero
    task automatic t_select();
        for (int k = 0; k < 8; k++) begin
            m.start();
            m.send({CTRL_CODE, 3'(k), 1'b0}, ack);
            m.stop();
            wait_idle();
            chk({7'h0, ack}, {7'h0, 3'(k) == strap});
        end
        strap <= 3'h0;
        repeat (8) @(posedge i_clk);
        dev(1'b0);
        m.stop();
        wait_idle();
        chk({7'h0, ack}, 8'h01);
        $display("select test done");
    endtask
    // full page, partial wrapping page, reads, then an overfilled buffer
    task automatic t_page();
        wr(8'h18, 8, 8'hA0);
        wr(8'h1F, 2, 8'h11);
        rd(8'h18, 7);
        dev(1'b1);
        m.recv(1'b0, d);
        m.stop();
        chk(d, exp_mem[8'h1F]);
        wr(8'h20, 17, 8'h30);
        rd(8'h20, 8);
        $display("page test done");
    endtask
    // protected write leaves the array unchanged
    task automatic t_protect();
        i_write_protect <= 1'b1;
        repeat (8) @(posedge i_clk);
        wr(8'h19, 1, 8'h55);
        i_write_protect <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(8'h19, 1);
        wr(8'h19, 1, 8'h66);
        rd(8'h19, 1);
        $display("protect test done");
    endtask
    // main sequence
    initial begin
        i_reset_n = 1'b0;
        i_write_protect = 1'b0;
        strap = 3'h5;
        fails = 0;
        tests_run = 0;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_select();
        t_page();
        t_protect();
        end_of_test();
    end
endmodule // test_twep_port
